// ===== shared/amc_pkg.sv
// Constants, field layouts and carrier types for the converter mode controller.
// Assumes a 100 MHz system clock and a converter reached through its own register port.
// What this block does
// - Mode register one is written only while the start bit and the comparator enable are both 0.
// - In hardware trigger no-wait mode triggers are at least 2 clocks plus start plus conversion apart.
// - In hardware trigger wait mode that spacing also adds the stabilization wait and 5 us.
// - A reference change first clears the comparator enable and waits at least 0.2 us.
// - A switch to the internal reference first discharges with both bits set for 1 us.
// - After the new reference is written, wait A, set the comparator enable, wait B, then start.
// - For the internal reference wait A is 5 us and wait B is 1 us plus two converter clocks.
// - For supply or pin references wait A is 4.8 us and wait B is 1 us plus two converter clocks.
// - Autonomous conversion is enabled only while an on-chip oscillator drives the system clock.
// - The wakeup bit is 0 in software trigger wait mode, 1 in hardware trigger wait mode, no-wait modes barred.
// - With autonomous conversion the trigger spacing also adds the transition time.
// - The wakeup bit is written for the trigger mode just before stop and cleared again after the return to normal.
package amc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int CE_OFF_NS = 200;
  localparam int DISCH_NS = 1000;
  localparam int WAIT_A_INT_NS = 5000;
  localparam int WAIT_A_EXT_NS = 4800;
  localparam int WAIT_B_NS = 1000;
  localparam int WAIT_B_FAD_CYC = 2;
  localparam int HW_WAIT_EXTRA_NS = 5000;
  localparam int TRIG_SYNC_CYC = 2;
  // Least times round up to whole clock cycles.
  localparam int CE_OFF_CYC = (CE_OFF_NS * CLK_MHZ + 999) / 1000;
  localparam int DISCH_CYC = (DISCH_NS * CLK_MHZ + 999) / 1000;
  localparam int WAIT_A_INT_CYC = (WAIT_A_INT_NS * CLK_MHZ + 999) / 1000;
  localparam int WAIT_A_EXT_CYC = (WAIT_A_EXT_NS * CLK_MHZ + 999) / 1000;
  localparam int WAIT_B_CYC = (WAIT_B_NS * CLK_MHZ + 999) / 1000;
  localparam int HW_WAIT_EXTRA_CYC = (HW_WAIT_EXTRA_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // Converter registers
  // ****************************************
  localparam logic [19:0] MODE2_ADDR = 20'hF_0010;
  localparam logic [7:0] MODE2_RESET = 8'h00;
  localparam int M2_REF_LO = 6;
  localparam int M2_NEG = 5;
  localparam int M2_RCK = 3;
  localparam int M2_WAKE = 2;
  localparam int M2_RES_LO = 0;
  localparam int M0_START = 7;
  localparam int M0_ENABLE = 0;
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_PIN = 2'h1;
  localparam logic [1:0] REF_INT = 2'h2;
  localparam logic [1:0] REF_DISCH = 2'h3;

  // ****************************************
  // Own registers
  // ****************************************
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam logic [7:0] TIME0_OFS = 8'h08;
  localparam logic [7:0] TIME1_OFS = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam int CMD_REF = 0;
  localparam int CMD_TRIG = 1;
  localparam int CMD_STOP = 2;
  localparam int CMD_START = 3;
  localparam int CMD_MODE1 = 4;
  localparam int CMD_CHAN_INT = 5;
  localparam int CMD_NEWREF_LO = 8;
  localparam int CMD_M1_LO = 16;
  localparam int CFG_MODE_LO = 0;
  localparam int CFG_CLK_ONCHIP = 2;
  localparam int CFG_NEG = 3;
  localparam int CFG_RCK = 4;
  localparam int CFG_RES_LO = 5;
  localparam int TIME_LO = 0;
  localparam int TIME_HI = 12;
  localparam int STAT_ERR = 1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {TRIG_SW_NOWAIT, TRIG_SW_WAIT, TRIG_HW_NOWAIT, TRIG_HW_WAIT}
    amc_trig_mode_type;
  typedef enum logic [1:0] {DEV_MODE0, DEV_MODE1, DEV_MODE2} amc_dev_reg_type;
  typedef struct packed {
    logic wr;
    amc_dev_reg_type target;
    logic [7:0] data;
  } amc_dev_req_type;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
  } amc_bus_wr_type;
  typedef struct packed {
    logic valid;
    logic refChange;
    logic enterStop;
    logic swStart;
    logic writeMode1;
    logic chanInternal;
    logic [1:0] newRef;
    logic [7:0] mode1Data;
  } amc_cmd_type;

endpackage

// ===== rtl/amc_wait_timer.sv
// Down counter that measures one settling wait.
// Assumes load is a one-cycle pulse and count is at least one.
`timescale 1ns/1ns
module amc_wait_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cntQ;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cntQ <= '0;
    end else if (load) begin
      cntQ <= count;
    end else if (cntQ != '0) begin
      cntQ <= cntQ - 1'b1;
    end
  end

  assign done = (cntQ == '0);
endmodule

// ===== rtl/amc_ahb_slave.sv
// AHB-Lite slave front end for the controller registers, zero wait states.
// Assumes single word transfers; other sizes and addresses above 0xFF are ignored.
`timescale 1ns/1ns
module amc_ahb_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Register side
  output logic [7:0] rdAddr,
  input wire logic [31:0] rdData,
  output amc_pkg::amc_bus_wr_type busWr
);
  import amc_pkg::*;

  logic take;
  logic hit;
  logic wrPendQ;
  logic [7:0] wrAddrQ;
  logic [31:0] hrdataQ;

  assign take = hsel && hready && htrans[1];
  assign hit = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
  assign rdAddr = haddr[7:0];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrPendQ <= 1'b0;
      wrAddrQ <= 8'h00;
      hrdataQ <= 32'h0000_0000;
    end else begin
      wrPendQ <= take && hwrite && hit;
      if (take) begin
        wrAddrQ <= haddr[7:0];
      end
      if (take && !hwrite) begin
        hrdataQ <= hit ? rdData : 32'h0000_0000;
      end
    end
  end

  assign hrdata = hrdataQ;
  // The slave never stretches a transfer and always answers OKAY.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign busWr.wr = wrPendQ;
  assign busWr.addr = wrAddrQ;
  assign busWr.data = hwdata;
endmodule

// ===== rtl/amc_ctrl.sv
// Host controller that sequences the converter mode registers on software command.
// Assumes the converter takes one register write per devReq pulse and reports
// conversion end and return from stop as one-cycle pulses on convDone and wakeDone.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ns
module amc_ctrl #(
  parameter int FAD_DIV = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter side
  output amc_pkg::amc_dev_req_type devReq,
  output logic hwTrigger,
  output logic stopReq,
  input wire logic convDone,
  input wire logic wakeDone
);
  import amc_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT_CEOFF, ST_WAIT_DISCH, ST_WAIT_A, ST_WAIT_B,
    ST_STOP_REQ, ST_IN_STOP} amc_state_type;
  localparam logic [15:0] WAIT_B_TOTAL = 16'(WAIT_B_CYC + WAIT_B_FAD_CYC * FAD_DIV);

  amc_state_type stateQ, stateD;
  amc_bus_wr_type busWr;
  amc_cmd_type cmdQ;
  amc_dev_req_type devReqQ, devReqD;
  amc_trig_mode_type trigMode;
  logic [7:0] rdAddr;
  logic [31:0] rdData;
  logic [31:0] cfgQ, time0Q, time1Q;
  logic [1:0] refQ, refD, newRefQ;
  logic ceQ, ceD, csQ, csD, wakeQ, wakeD;
  logic errQ, errSet, cmdTake, tmrLoad, tmrDone, stopD;
  logic [15:0] tmrCount, trigSpacing;
  logic [15:0] sinceTrigQ, sinceCeOffQ, sinceDischQ, sinceRefQ, sinceCeOnQ;
  logic trigPendQ, hwTrigQ, stopReqQ, fire;
  logic cmdWr;

  amc_ahb_slave u_slave (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rdAddr(rdAddr), .rdData(rdData), .busWr(busWr)
  );

  amc_wait_timer #(.W(16)) u_timer (
    .clk(clk), .nrst(nrst), .load(tmrLoad), .count(tmrCount), .done(tmrDone)
  );

  function automatic logic [7:0] mode2Byte(input logic [1:0] r, input logic w,
                                           input logic [31:0] c);
    logic [7:0] b;
    b = MODE2_RESET;
    b[M2_REF_LO +: 2] = r;
    b[M2_NEG] = c[CFG_NEG];
    b[M2_RCK] = c[CFG_RCK];
    b[M2_WAKE] = w;
    b[M2_RES_LO +: 2] = c[CFG_RES_LO +: 2];
    return b;
  endfunction

  function automatic logic [7:0] mode0Byte(input logic s, input logic e);
    logic [7:0] b;
    b = 8'h00;
    b[M0_START] = s;
    b[M0_ENABLE] = e;
    return b;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  assign trigMode = amc_trig_mode_type'(cfgQ[CFG_MODE_LO +: 2]);
  assign cmdWr = busWr.wr && (busWr.addr == CMD_OFS);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfgQ <= 32'h0000_0000;
      time0Q <= 32'h0000_0000;
      time1Q <= 32'h0000_0000;
    end else if (busWr.wr) begin
      if (busWr.addr == CFG_OFS) begin
        cfgQ <= {25'h000_0000, busWr.data[6:0]};
      end else if (busWr.addr == TIME0_OFS) begin
        time0Q <= {8'h00, busWr.data[23:0]};
      end else if (busWr.addr == TIME1_OFS) begin
        time1Q <= {8'h00, busWr.data[23:0]};
      end
    end
  end

  always_comb begin
    if (rdAddr == CFG_OFS) begin
      rdData = cfgQ;
    end else if (rdAddr == TIME0_OFS) begin
      rdData = time0Q;
    end else if (rdAddr == TIME1_OFS) begin
      rdData = time1Q;
    end else if (rdAddr == STAT_OFS) begin
      rdData = {23'h00_0000, stateQ == ST_IN_STOP, trigPendQ, csQ, ceQ, wakeQ, refQ, errQ,
                (stateQ != ST_IDLE) || cmdQ.valid};
    end else begin
      rdData = 32'h0000_0000;
    end
  end

  // Commands wait here until the sequencer is idle; a second one meanwhile is an error.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmdQ <= '0;
    end else if (cmdWr && !cmdQ.valid) begin
      cmdQ.valid <= busWr.data[CMD_REF] | busWr.data[CMD_STOP] | busWr.data[CMD_START]
                    | busWr.data[CMD_MODE1];
      cmdQ.refChange <= busWr.data[CMD_REF];
      cmdQ.enterStop <= busWr.data[CMD_STOP];
      cmdQ.swStart <= busWr.data[CMD_START];
      cmdQ.writeMode1 <= busWr.data[CMD_MODE1];
      cmdQ.chanInternal <= busWr.data[CMD_CHAN_INT];
      cmdQ.newRef <= busWr.data[CMD_NEWREF_LO +: 2];
      cmdQ.mode1Data <= busWr.data[CMD_M1_LO +: 8];
    end else if (cmdTake) begin
      cmdQ.valid <= 1'b0;
    end
  end

  // A new fault wins over a clear written in the same cycle.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      errQ <= 1'b0;
    end else begin
      errQ <= (errQ && !(busWr.wr && busWr.addr == STAT_OFS && busWr.data[STAT_ERR]))
              || errSet || (cmdWr && cmdQ.valid && busWr.data[4:0] != 5'h00);
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    stateD = stateQ;
    tmrLoad = 1'b0;
    tmrCount = 16'h0000;
    devReqD = '0;
    refD = refQ;
    ceD = ceQ;
    csD = csQ;
    wakeD = wakeQ;
    errSet = 1'b0;
    cmdTake = 1'b0;
    stopD = 1'b0;
    case (stateQ)
      ST_IDLE: begin
        if (convDone && csQ) begin
          csD = 1'b0;
          devReqD = '{wr: 1'b1, target: DEV_MODE0, data: mode0Byte(1'b0, ceQ)};
        end else if (cmdQ.valid) begin
          cmdTake = 1'b1;
          if (cmdQ.refChange) begin
            if (csQ) begin
              errSet = 1'b1;
            end else begin
              ceD = 1'b0;
              devReqD = '{wr: 1'b1, target: DEV_MODE0, data: mode0Byte(1'b0, 1'b0)};
              tmrLoad = 1'b1;
              tmrCount = 16'(CE_OFF_CYC);
              stateD = ST_WAIT_CEOFF;
            end
          end else if (cmdQ.writeMode1) begin
            if (csQ || ceQ) begin
              errSet = 1'b1;
            end else begin
              devReqD = '{wr: 1'b1, target: DEV_MODE1, data: cmdQ.mode1Data};
            end
          end else if (cmdQ.swStart) begin
            // The enable only reaches 1 after wait A, and commands are only taken again once wait B has run.
            if (!ceQ || wakeQ || (cmdQ.chanInternal && refQ == REF_INT)) begin
              errSet = 1'b1;
            end else begin
              csD = 1'b1;
              devReqD = '{wr: 1'b1, target: DEV_MODE0, data: mode0Byte(1'b1, 1'b1)};
            end
          end else if (cmdQ.enterStop) begin
            if (!cfgQ[CFG_CLK_ONCHIP] || trigMode == TRIG_SW_NOWAIT
                || trigMode == TRIG_HW_NOWAIT) begin
              errSet = 1'b1;
            end else begin
              wakeD = (trigMode == TRIG_HW_WAIT);
              devReqD = '{wr: 1'b1, target: DEV_MODE2,
                          data: mode2Byte(refQ, wakeD, cfgQ)};
              stateD = ST_STOP_REQ;
            end
          end
        end
      end
      ST_WAIT_CEOFF: begin
        if (tmrDone) begin
          tmrLoad = 1'b1;
          if (newRefQ == REF_INT) begin
            refD = REF_DISCH;
            tmrCount = 16'(DISCH_CYC);
            stateD = ST_WAIT_DISCH;
          end else begin
            refD = newRefQ;
            tmrCount = 16'(WAIT_A_EXT_CYC);
            stateD = ST_WAIT_A;
          end
          devReqD = '{wr: 1'b1, target: DEV_MODE2, data: mode2Byte(refD, wakeQ, cfgQ)};
        end
      end
      ST_WAIT_DISCH: begin
        if (tmrDone) begin
          refD = newRefQ;
          devReqD = '{wr: 1'b1, target: DEV_MODE2, data: mode2Byte(refD, wakeQ, cfgQ)};
          tmrLoad = 1'b1;
          tmrCount = 16'(WAIT_A_INT_CYC);
          stateD = ST_WAIT_A;
        end
      end
      ST_WAIT_A: begin
        if (tmrDone) begin
          ceD = 1'b1;
          devReqD = '{wr: 1'b1, target: DEV_MODE0, data: mode0Byte(1'b0, 1'b1)};
          tmrLoad = 1'b1;
          tmrCount = WAIT_B_TOTAL;
          stateD = ST_WAIT_B;
        end
      end
      ST_WAIT_B: begin
        if (tmrDone) begin
          stateD = ST_IDLE;
        end
      end
      ST_STOP_REQ: begin
        stopD = 1'b1;
        stateD = ST_IN_STOP;
      end
      ST_IN_STOP: begin
        if (wakeDone) begin
          wakeD = 1'b0;
          devReqD = '{wr: 1'b1, target: DEV_MODE2, data: mode2Byte(refQ, 1'b0, cfgQ)};
          stateD = ST_IDLE;
        end
      end
      default: begin
        stateD = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stateQ <= ST_IDLE;
      devReqQ <= '0;
      stopReqQ <= 1'b0;
      refQ <= MODE2_RESET[M2_REF_LO +: 2];
      wakeQ <= MODE2_RESET[M2_WAKE];
      ceQ <= 1'b0;
      csQ <= 1'b0;
      newRefQ <= REF_SUPPLY;
    end else begin
      stateQ <= stateD;
      devReqQ <= devReqD;
      stopReqQ <= stopD;
      refQ <= refD;
      wakeQ <= wakeD;
      ceQ <= ceD;
      csQ <= csD;
      if (cmdTake) begin
        newRefQ <= cmdQ.newRef;
      end
    end
  end

  // ****************************************
  // Hardware trigger pacing
  // ****************************************
  // Triggers are held back rather than refused, so software may queue one early.
  always_comb begin
    trigSpacing = 16'(TRIG_SYNC_CYC) + {4'h0, time0Q[TIME_LO +: 12]}
                  + {4'h0, time0Q[TIME_HI +: 12]};
    if (trigMode == TRIG_HW_WAIT) begin
      trigSpacing = trigSpacing + {4'h0, time1Q[TIME_LO +: 12]}
                    + 16'(HW_WAIT_EXTRA_CYC);
    end
    if (wakeQ) begin
      trigSpacing = trigSpacing + {4'h0, time1Q[TIME_HI +: 12]};
    end
  end

  assign fire = trigPendQ && (trigMode == TRIG_HW_NOWAIT || trigMode == TRIG_HW_WAIT)
                && sinceTrigQ >= trigSpacing;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trigPendQ <= 1'b0;
      hwTrigQ <= 1'b0;
    end else begin
      trigPendQ <= (trigPendQ && !fire) || (cmdWr && busWr.data[CMD_TRIG]);
      hwTrigQ <= fire;
    end
  end

  // Elapsed-time counters saturate so a long idle never wraps into a short gap.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sinceTrigQ <= 16'hFFFF;
      sinceCeOffQ <= 16'h0000;
      sinceDischQ <= 16'h0000;
      sinceRefQ <= 16'h0000;
      sinceCeOnQ <= 16'h0000;
    end else begin
      sinceTrigQ <= fire ? 16'h0000 : sinceTrigQ + {15'h0000, sinceTrigQ != 16'hFFFF};
      sinceCeOffQ <= (ceQ && !ceD) ? 16'h0000
                     : sinceCeOffQ + {15'h0000, sinceCeOffQ != 16'hFFFF};
      sinceDischQ <= (refD == REF_DISCH && refQ != REF_DISCH) ? 16'h0000
                     : sinceDischQ + {15'h0000, sinceDischQ != 16'hFFFF};
      sinceRefQ <= (refD != refQ) ? 16'h0000 : sinceRefQ + {15'h0000, sinceRefQ != 16'hFFFF};
      sinceCeOnQ <= (ceD && !ceQ) ? 16'h0000
                    : sinceCeOnQ + {15'h0000, sinceCeOnQ != 16'hFFFF};
    end
  end

  assign devReq = devReqQ;
  assign hwTrigger = hwTrigQ;
  assign stopReq = stopReqQ;

  // ****************************************
  // Checks
  // ****************************************
  a_mode1_halted: assert property (@(posedge clk) disable iff (!nrst)
    devReqQ.wr && devReqQ.target == DEV_MODE1 |-> !csQ && !ceQ)
    else $error("Mode register one written while conversion runs.");
  a_space_nowait: assert property (@(posedge clk) disable iff (!nrst)
    hwTrigQ && trigMode == TRIG_HW_NOWAIT |->
    $past(sinceTrigQ) >= 16'(TRIG_SYNC_CYC) + time0Q[11:0] + time0Q[23:12])
    else $error("No-wait triggers too close together.");
  a_space_wait: assert property (@(posedge clk) disable iff (!nrst)
    hwTrigQ && trigMode == TRIG_HW_WAIT |-> $past(sinceTrigQ) >= 16'(TRIG_SYNC_CYC)
    + time0Q[11:0] + time0Q[23:12] + time1Q[11:0] + 16'(HW_WAIT_EXTRA_CYC))
    else $error("Wait-mode triggers too close together.");
  a_space_auto: assert property (@(posedge clk) disable iff (!nrst)
    hwTrigQ && $past(wakeQ) |-> $past(sinceTrigQ) >= 16'(TRIG_SYNC_CYC) + time0Q[11:0]
    + time0Q[23:12] + time1Q[11:0] + time1Q[23:12] + 16'(HW_WAIT_EXTRA_CYC))
    else $error("Autonomous triggers too close together.");
  a_ceoff_wait: assert property (@(posedge clk) disable iff (!nrst)
    devReqQ.wr && devReqQ.target == DEV_MODE2 && refQ != $past(refQ) |->
    !ceQ && sinceCeOffQ >= 16'(CE_OFF_CYC))
    else $error("Reference changed too soon after enable cleared.");
  a_discharge_first: assert property (@(posedge clk) disable iff (!nrst)
    $changed(refQ) && refQ == REF_INT |->
    $past(refQ) == REF_DISCH && sinceDischQ >= 16'(DISCH_CYC))
    else $error("Internal reference selected without full discharge.");
  a_wait_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(ceQ) |-> sinceRefQ >= (refQ == REF_INT ? 16'(WAIT_A_INT_CYC) : 16'(WAIT_A_EXT_CYC)))
    else $error("Enable set before the reference settled.");
  a_wait_b: assert property (@(posedge clk) disable iff (!nrst)
    $rose(csQ) |-> ceQ && sinceCeOnQ >= WAIT_B_TOTAL)
    else $error("Conversion started before the enable settled.");
  a_clock_source: assert property (@(posedge clk) disable iff (!nrst)
    $rose(wakeQ) |-> cfgQ[CFG_CLK_ONCHIP])
    else $error("Autonomous mode set without an on-chip oscillator.");
  a_wake_mode: assert property (@(posedge clk) disable iff (!nrst)
    stopReqQ |-> (trigMode == TRIG_SW_WAIT && !wakeQ) || (trigMode == TRIG_HW_WAIT && wakeQ))
    else $error("Wakeup bit wrong for the trigger mode.");
  a_wake_before_stop: assert property (@(posedge clk) disable iff (!nrst)
    $rose(stopReqQ) |-> $past(devReqQ.wr) && $past(devReqQ.target) == DEV_MODE2)
    else $error("Stop requested without the wakeup write just before.");
  a_wake_cleared: assert property (@(posedge clk) disable iff (!nrst)
    stateQ == ST_IN_STOP && wakeDone |=> !wakeQ && devReqQ.wr ##1 stateQ == ST_IDLE)
    else $error("Wakeup bit not cleared after return from stop.");
endmodule

// ===== tb/amc_dev_model.sv
// Behavioural converter: register writes logged, stop state and wake answer.
// Assumes the controller writes one converter register per devReq pulse.
`timescale 1ns/1ns
module amc_dev_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Controller side
  input wire amc_pkg::amc_dev_req_type devReq,
  input wire logic stopReq,
  input wire logic hwTrigger,
  output logic convDone,
  output logic wakeDone
);
  import amc_pkg::*;
  logic [7:0] mode2Q = MODE2_RESET;
  logic [9:0] wrLog[$];
  int stamp[$];
  int cycQ;
  int stopCyc;
  int wakeCnt;
  int trigStamp[$];
  initial begin
    convDone = 1'b0;
    wakeDone = 1'b0;
  end
  always @(posedge clk) begin
    cycQ <= cycQ + 1;
    convDone <= devReq.wr && devReq.target == DEV_MODE0 && devReq.data[M0_START];
    wakeDone <= wakeCnt == 1;
    if (wakeCnt > 0) wakeCnt <= wakeCnt - 1;
    if (devReq.wr) begin
      wrLog.push_back({devReq.target, devReq.data});
      stamp.push_back(cycQ);
      if (devReq.target == DEV_MODE2) mode2Q <= devReq.data;
    end
    // A second trigger within four clocks of the last one is not taken unless the wakeup bit is set.
    if (hwTrigger && (trigStamp.size() == 0 || cycQ - trigStamp[$] > 4 || mode2Q[M2_WAKE])) begin
      trigStamp.push_back(cycQ);
    end
    // A slow wake makes the controller hold its stop state for a while.
    if (stopReq) begin
      stopCyc <= cycQ;
      wakeCnt <= 8;
    end
  end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the converter mode controller.
// Assumes the zero-wait register slave and the behavioural converter model.
`timescale 1ns/1ns
module tb;
  import amc_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready, hresp, hwTrigger, stopReq, convDone, wakeDone;
  amc_dev_req_type devReq;
  int failures = 0, comparisons = 0;
  amc_ctrl amc_ctrl_inst (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .devReq(devReq), .hwTrigger(hwTrigger),
    .stopReq(stopReq), .convDone(convDone), .wakeDone(wakeDone));
  amc_dev_model amc_dev_model_inst (.clk(clk), .nrst(nrst), .devReq(devReq),
    .stopReq(stopReq), .hwTrigger(hwTrigger), .convDone(convDone), .wakeDone(wakeDone));
  initial forever #5 clk = ~clk;
  task automatic results();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic edgeRdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      failures++;
      results();
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    edgeRdy();
    htrans <= 2'h0;
    hwdata <= d;
    edgeRdy();
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask
  // Polls the busy bit; each poll is a full bus read, so the bound is generous.
  task automatic idle();
    int n;
    for (n = 0; n < 1000; n++) begin
      bus(1'b0, 8'h10, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (n == 1000) begin
      failures++;
      results();
    end
  endtask
  function automatic logic [9:0] wr(input int i);
    return amc_dev_model_inst.wrLog[i];
  endfunction
  function automatic int gap(input int i);
    return amc_dev_model_inst.stamp[i + 1] - amc_dev_model_inst.stamp[i];
  endfunction
  function automatic int tgap(input int i);
    return amc_dev_model_inst.trigStamp[i + 1] - amc_dev_model_inst.trigStamp[i];
  endfunction
  task automatic t_ref();
    bus(1'b1, 8'h00, 32'h0201);
    idle();
    chk(amc_dev_model_inst.stamp.size(), 4);
    chk(wr(0), 10'h000);
    chk(wr(1), 10'h2C0);
    chk(wr(2), 10'h280);
    chk(wr(3), 10'h001);
    chk(amc_dev_model_inst.mode2Q, 8'h80);
    chk(gap(0) >= CE_OFF_CYC, 1'b1);
    chk(gap(1) >= DISCH_CYC, 1'b1);
    chk(gap(2) >= WAIT_A_INT_CYC, 1'b1);
    $display("t_ref done");
  endtask
  task automatic t_start();
    bus(1'b1, 8'h00, 32'h0008);
    idle();
    chk(wr(4), 10'h081);
    chk(gap(3) >= WAIT_B_CYC + WAIT_B_FAD_CYC, 1'b1);
    repeat (2) @(posedge clk);
    chk(wr(5), 10'h001);
    $display("t_start done");
  endtask
  task automatic t_refuse();
    logic [7:0] cfg[4] = '{8'h3, 8'h3, 8'h3, 8'h6};
    logic [7:0] cmd[4] = '{8'h10, 8'h28, 8'h04, 8'h04};
    int n0;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h04, cfg[i]);
      n0 = amc_dev_model_inst.stamp.size();
      bus(1'b1, 8'h00, cmd[i]);
      idle();
      chk(rd[1], 1'b1);
      chk(amc_dev_model_inst.stamp.size(), n0);
      bus(1'b1, 8'h10, 32'h2);
      idle();
      chk(rd[1], 1'b0);
    end
    bus(1'b1, 8'h40, 32'hFF);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    $display("t_refuse done");
  endtask
  task automatic t_stop();
    logic [7:0] cfg[2] = '{8'h7, 8'h5};
    int n0;
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 8'h04, cfg[i]);
      n0 = amc_dev_model_inst.stamp.size();
      bus(1'b1, 8'h00, 32'h4);
      idle();
      chk(wr(n0), (i == 0) ? 10'h284 : 10'h280);
      chk(amc_dev_model_inst.stopCyc, amc_dev_model_inst.stamp[n0] + 1);
      chk(wr(n0 + 1), 10'h280);
    end
    $display("t_stop done");
  endtask
  // Two queued triggers in each hardware mode; start 3, conversion 5, stabilization 4.
  task automatic t_trig();
    int n;
    int lim;
    bus(1'b1, 8'h08, 32'h0000_5003);
    bus(1'b1, 8'h0C, 32'h0000_0004);
    for (int m = 2; m < 4; m++) begin
      bus(1'b1, 8'h04, m);
      n = amc_dev_model_inst.trigStamp.size();
      bus(1'b1, 8'h00, 32'h2);
      bus(1'b1, 8'h00, 32'h2);
      repeat (600) @(posedge clk);
      lim = TRIG_SYNC_CYC + 8 + ((m == 3) ? 4 + HW_WAIT_EXTRA_CYC : 0);
      chk(amc_dev_model_inst.trigStamp.size(), n + 2);
      chk(tgap(n) >= lim, 1'b1);
      chk(tgap(n) <= lim + 4, 1'b1);
    end
    $display("t_trig done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_ref();
    t_start();
    t_refuse();
    t_stop();
    t_trig();
    results();
  end
endmodule
